// file: hw/fw_update_loader.sv
// Serial firmware update loader: entry, menu, XModem-CRC receive, flash programming
`timescale 1ns/1ps
`default_nettype none
`include "fw_loader_defines.svh"

module fw_update_loader #(
  parameter logic [`LDR_TIMER_W-1:0] FIRST_BLK_CYCLES = `LDR_TIMER_W'(`LDR_FIRST_BLK_CYCLES),
  parameter logic [`LDR_TIMER_W-1:0] POLL_CYCLES = `LDR_TIMER_W'(`LDR_POLL_CYCLES)
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic din_i,
  input wire logic sleep_request_line_i,
  input wire logic rts_i,
  input wire logic app_valid_i,
  input wire logic app_jump_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  input wire logic tx_ready_i,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  output logic flash_req_o,
  output logic [`LDR_ADDR_W-1:0] flash_addr_o,
  output logic [7:0] flash_wdata_o,
  input wire logic flash_ack_i,
  input wire logic flash_err_i,
  output logic app_run_o,
  output logic loader_active_o,
  output logic load_busy_o,
  output logic launch_o
);

  fw_loader_pkg::ldr_state_t state;
  fw_loader_pkg::ldr_state_t ret_state;
  fw_loader_pkg::msg_t snd_sel;
  logic [7:0] snd_ch;
  logic snd_issued;
  logic snd_busy;
  logic [7:0] blk_buf [0:`LDR_BLOCK_BYTES-1];
  logic [6:0] cnt;
  logic [7:0] blk_num;
  logic [7:0] blk_inv;
  logic [7:0] expected;
  logic first_blk;
  logic loaded;
  logic [3:0] retries;
  logic [15:0] crc;
  logic [15:0] rx_crc;
  logic [`LDR_TIMER_W-1:0] wait_timer;
  logic [`LDR_TIMER_W-1:0] poll_timer;
  logic rx_hit;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int b = 0; b < 8; b++) begin
      r = r[15] ? ((r << 1) ^ `LDR_CRC_POLY) : (r << 1);
    end
    crc_byte = r;
  endfunction

  assign rx_hit = rx_valid_i && (state != fw_loader_pkg::ST_SEND);

  // ****************************************
  // Outgoing bytes
  // ****************************************
  ldr_msg_sender u_sender (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .start_i(state == fw_loader_pkg::ST_SEND && !snd_issued),
    .sel_i(snd_sel),
    .ch_i(snd_ch),
    .tx_ready_i(tx_ready_i),
    .tx_data_o(tx_data_o),
    .tx_valid_o(tx_valid_o),
    .busy_o(snd_busy)
  );

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      snd_issued <= 1'b0;
    end else begin
      // Clears when a message ends so a chained message restarts the sender
      snd_issued <= (state == fw_loader_pkg::ST_SEND) && !(snd_issued && !snd_busy);
    end
  end

  // ****************************************
  // Block buffer and CRC
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (state == fw_loader_pkg::ST_XM_DATA && rx_hit) begin
      blk_buf[cnt] <= rx_data_i;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      crc <= 16'h0000;
    end else if (state == fw_loader_pkg::ST_XM_BLK) begin
      crc <= 16'h0000;
    end else if (state == fw_loader_pkg::ST_XM_DATA && rx_hit) begin
      crc <= crc_byte(crc, rx_data_i);
    end
  end

  // ****************************************
  // Timers while waiting for a block
  // ****************************************
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wait_timer <= '0;
      poll_timer <= '0;
    end else if (state == fw_loader_pkg::ST_XM_HDR) begin
      wait_timer <= wait_timer + `LDR_TIMER_W'(1);
      poll_timer <= poll_timer + `LDR_TIMER_W'(1);
    end else begin
      if (state != fw_loader_pkg::ST_SEND) begin
        wait_timer <= '0;
      end
      poll_timer <= '0;
    end
  end

  // ****************************************
  // Status outputs
  // ****************************************
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      app_run_o <= 1'b0;
      loader_active_o <= 1'b0;
    end else begin
      app_run_o <= (state == fw_loader_pkg::ST_APP);
      loader_active_o <= (state != fw_loader_pkg::ST_APP && state != fw_loader_pkg::ST_ENTRY);
    end
  end

  // ****************************************
  // Main sequencer
  // ****************************************
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state <= fw_loader_pkg::ST_ENTRY;
      ret_state <= fw_loader_pkg::ST_MENU;
      snd_sel <= fw_loader_pkg::MSG_PROMPT;
      snd_ch <= 8'h00;
      cnt <= 7'h00;
      blk_num <= 8'h00;
      blk_inv <= 8'h00;
      expected <= 8'h01;
      first_blk <= 1'b1;
      loaded <= 1'b0;
      retries <= 4'h0;
      rx_crc <= 16'h0000;
      load_busy_o <= 1'b0;
      launch_o <= 1'b0;
      flash_req_o <= 1'b0;
      flash_addr_o <= '0;
      flash_wdata_o <= 8'h00;
    end else begin
      launch_o <= 1'b0;
      case (state)
        fw_loader_pkg::ST_ENTRY: begin
          if (!app_valid_i || (!sleep_request_line_i && rts_i && !din_i)) begin
            snd_sel <= fw_loader_pkg::MSG_PROMPT;
            ret_state <= fw_loader_pkg::ST_MENU;
            state <= fw_loader_pkg::ST_SEND;
          end else begin
            state <= fw_loader_pkg::ST_APP;
          end
        end
        fw_loader_pkg::ST_APP: begin
          if (app_jump_i) begin
            snd_sel <= fw_loader_pkg::MSG_PROMPT;
            ret_state <= fw_loader_pkg::ST_MENU;
            state <= fw_loader_pkg::ST_SEND;
          end
        end
        fw_loader_pkg::ST_SEND: begin
          if (snd_issued && !snd_busy) begin
            state <= ret_state;
          end
        end
        fw_loader_pkg::ST_MENU: begin
          if (rx_hit && rx_data_i == `LDR_CH_CMD_UPLOAD) begin
            loaded <= 1'b0;
            state <= fw_loader_pkg::ST_XM_START;
          end else if (rx_hit && rx_data_i == `LDR_CH_CMD_RUN && loaded) begin
            launch_o <= 1'b1;
            state <= fw_loader_pkg::ST_APP;
          end else if (rx_hit && rx_data_i == `LDR_CH_CR) begin
            snd_sel <= fw_loader_pkg::MSG_PROMPT;
            ret_state <= fw_loader_pkg::ST_MENU;
            state <= fw_loader_pkg::ST_SEND;
          end
        end
        fw_loader_pkg::ST_XM_START: begin
          load_busy_o <= 1'b1;
          first_blk <= 1'b1;
          expected <= 8'h01;
          retries <= 4'h0;
          flash_addr_o <= '0;
          snd_sel <= fw_loader_pkg::MSG_SINGLE;
          snd_ch <= `LDR_CH_CRC_POLL;
          ret_state <= fw_loader_pkg::ST_XM_HDR;
          state <= fw_loader_pkg::ST_SEND;
        end
        fw_loader_pkg::ST_XM_HDR: begin
          if (rx_hit && rx_data_i == `LDR_CH_SOH) begin
            state <= fw_loader_pkg::ST_XM_BLK;
          end else if (rx_hit && rx_data_i == `LDR_CH_EOT && !first_blk) begin
            loaded <= 1'b1;
            load_busy_o <= 1'b0;
            snd_sel <= fw_loader_pkg::MSG_SINGLE;
            snd_ch <= `LDR_CH_ACK;
            ret_state <= fw_loader_pkg::ST_XM_CHECK;
            state <= fw_loader_pkg::ST_SEND;
          end else if ((rx_hit && rx_data_i == `LDR_CH_CAN) ||
                       (first_blk && wait_timer >= FIRST_BLK_CYCLES)) begin
            load_busy_o <= 1'b0;
            snd_sel <= fw_loader_pkg::MSG_ABORTED;
            ret_state <= fw_loader_pkg::ST_ENTRY;
            state <= fw_loader_pkg::ST_SEND;
          end else if (first_blk && poll_timer >= POLL_CYCLES) begin
            snd_sel <= fw_loader_pkg::MSG_SINGLE;
            snd_ch <= `LDR_CH_CRC_POLL;
            ret_state <= fw_loader_pkg::ST_XM_HDR;
            state <= fw_loader_pkg::ST_SEND;
          end
        end
        fw_loader_pkg::ST_XM_BLK: begin
          cnt <= 7'h00;
          if (rx_hit) begin
            blk_num <= rx_data_i;
            state <= fw_loader_pkg::ST_XM_BLKN;
          end
        end
        fw_loader_pkg::ST_XM_BLKN: begin
          if (rx_hit) begin
            blk_inv <= rx_data_i;
            state <= fw_loader_pkg::ST_XM_DATA;
          end
        end
        fw_loader_pkg::ST_XM_DATA: begin
          if (rx_hit) begin
            cnt <= cnt + 7'h01;
            if (cnt == `LDR_LAST_BYTE) begin
              state <= fw_loader_pkg::ST_XM_CRCH;
            end
          end
        end
        fw_loader_pkg::ST_XM_CRCH: begin
          if (rx_hit) begin
            rx_crc[15:8] <= rx_data_i;
            state <= fw_loader_pkg::ST_XM_CRCL;
          end
        end
        fw_loader_pkg::ST_XM_CRCL: begin
          if (rx_hit) begin
            rx_crc[7:0] <= rx_data_i;
            state <= fw_loader_pkg::ST_XM_CHECK;
          end
        end
        fw_loader_pkg::ST_XM_CHECK: begin
          snd_sel <= fw_loader_pkg::MSG_SINGLE;
          state <= fw_loader_pkg::ST_SEND;
          ret_state <= fw_loader_pkg::ST_XM_HDR;
          if (loaded) begin
            snd_sel <= fw_loader_pkg::MSG_COMPLETE;
            ret_state <= fw_loader_pkg::ST_ENTRY;
          end else if (blk_num != ~blk_inv || crc != rx_crc) begin
            retries <= retries + 4'h1;
            snd_ch <= `LDR_CH_NAK;
            if (retries == `LDR_MAX_RETRIES - 4'h1) begin
              load_busy_o <= 1'b0;
              snd_sel <= fw_loader_pkg::MSG_ABORTED;
              ret_state <= fw_loader_pkg::ST_ENTRY;
            end
          end else if (!first_blk && blk_num == expected - 8'h01) begin
            snd_ch <= `LDR_CH_ACK;
          end else if (blk_num != expected) begin
            load_busy_o <= 1'b0;
            snd_sel <= fw_loader_pkg::MSG_ABORTED;
            ret_state <= fw_loader_pkg::ST_ENTRY;
          end else begin
            retries <= 4'h0;
            cnt <= 7'h00;
            flash_wdata_o <= blk_buf[0];
            flash_req_o <= 1'b1;
            state <= fw_loader_pkg::ST_XM_PROG;
          end
        end
        fw_loader_pkg::ST_XM_PROG: begin
          if (flash_ack_i) begin
            if (flash_err_i) begin
              flash_req_o <= 1'b0;
              load_busy_o <= 1'b0;
              snd_sel <= fw_loader_pkg::MSG_ABORTED;
              ret_state <= fw_loader_pkg::ST_ENTRY;
              state <= fw_loader_pkg::ST_SEND;
            end else begin
              flash_addr_o <= flash_addr_o + `LDR_ADDR_W'(1);
              cnt <= cnt + 7'h01;
              flash_wdata_o <= blk_buf[cnt + 7'h01];
              if (cnt == `LDR_LAST_BYTE) begin
                flash_req_o <= 1'b0;
                first_blk <= 1'b0;
                expected <= expected + 8'h01;
                snd_sel <= fw_loader_pkg::MSG_SINGLE;
                snd_ch <= `LDR_CH_ACK;
                ret_state <= fw_loader_pkg::ST_XM_HDR;
                state <= fw_loader_pkg::ST_SEND;
              end
            end
          end
        end
        default: begin
          state <= fw_loader_pkg::ST_ENTRY;
        end
      endcase
      // Menu after complete or abort, never back to the application
      if (state == fw_loader_pkg::ST_SEND && snd_issued && !snd_busy &&
          ret_state == fw_loader_pkg::ST_ENTRY) begin
        snd_sel <= fw_loader_pkg::MSG_PROMPT;
        ret_state <= fw_loader_pkg::ST_MENU;
        state <= fw_loader_pkg::ST_SEND;
      end
    end
  end

endmodule
`default_nettype wire

// file: include/fw_loader_defines.svh
// Constants for the serial firmware update loader
`ifndef FW_LOADER_DEFINES_SVH
`define FW_LOADER_DEFINES_SVH

// ****************************************
// Clock and timing
// ****************************************
`define LDR_CLK_HZ 64'd200000000
`define LDR_FIRST_BLK_TIMEOUT_S 64'd60
`define LDR_FIRST_BLK_CYCLES (`LDR_FIRST_BLK_TIMEOUT_S * `LDR_CLK_HZ)
`define LDR_POLL_INTERVAL_S 64'd1
`define LDR_POLL_CYCLES (`LDR_POLL_INTERVAL_S * `LDR_CLK_HZ)
`define LDR_TIMER_W 36

// ****************************************
// Characters and protocol
// ****************************************
`define LDR_CH_CMD_UPLOAD 8'h31
`define LDR_CH_CMD_RUN 8'h32
`define LDR_CH_CR 8'h0d
`define LDR_CH_LF 8'h0a
`define LDR_CH_SOH 8'h01
`define LDR_CH_EOT 8'h04
`define LDR_CH_ACK 8'h06
`define LDR_CH_NAK 8'h15
`define LDR_CH_CAN 8'h18
`define LDR_CH_CRC_POLL 8'h43
`define LDR_BLOCK_BYTES 8'd128
`define LDR_LAST_BYTE 7'h7f
`define LDR_CRC_POLY 16'h1021
`define LDR_MAX_RETRIES 4'ha
`define LDR_ADDR_W 24

// ****************************************
// Message lengths
// ****************************************
`define LDR_LEN_PROMPT 4'h6
`define LDR_LEN_COMPLETE 4'hc
`define LDR_LEN_ABORTED 4'hb
`define LDR_LEN_SINGLE 4'h1

`endif

// file: include/fw_loader_pkg.sv
// Types shared by the loader modules
package fw_loader_pkg;

  typedef enum logic [1:0] {
    MSG_PROMPT = 2'b00,
    MSG_COMPLETE = 2'b01,
    MSG_ABORTED = 2'b10,
    MSG_SINGLE = 2'b11
  } msg_t;

  typedef enum logic [3:0] {
    ST_ENTRY = 4'b0000,
    ST_APP = 4'b0001,
    ST_SEND = 4'b0010,
    ST_MENU = 4'b0011,
    ST_XM_HDR = 4'b0100,
    ST_XM_BLK = 4'b0101,
    ST_XM_BLKN = 4'b0110,
    ST_XM_DATA = 4'b0111,
    ST_XM_CRCH = 4'b1000,
    ST_XM_CRCL = 4'b1001,
    ST_XM_CHECK = 4'b1010,
    ST_XM_PROG = 4'b1011,
    ST_XM_START = 4'b1100
  } ldr_state_t;

endpackage

// file: hw/ldr_msg_sender.sv
// Message text generator and byte sender for the loader
`timescale 1ns/1ps
`default_nettype none
`include "fw_loader_defines.svh"

module ldr_msg_sender (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire fw_loader_pkg::msg_t sel_i,
  input wire logic [7:0] ch_i,
  input wire logic tx_ready_i,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  output logic busy_o
);

  fw_loader_pkg::msg_t cur;
  logic [7:0] single;
  logic [3:0] idx;

  function automatic logic [3:0] msg_len(input fw_loader_pkg::msg_t m);
    case (m)
      fw_loader_pkg::MSG_PROMPT: msg_len = `LDR_LEN_PROMPT;
      fw_loader_pkg::MSG_COMPLETE: msg_len = `LDR_LEN_COMPLETE;
      fw_loader_pkg::MSG_ABORTED: msg_len = `LDR_LEN_ABORTED;
      default: msg_len = `LDR_LEN_SINGLE;
    endcase
  endfunction

  // Text: CR LF prompt, CR LF "complete" CR LF, CR LF "aborted" CR LF
  function automatic logic [7:0] msg_char(input fw_loader_pkg::msg_t m, input logic [3:0] i,
                                          input logic [7:0] c);
    logic [7:0] r;
    r = 8'h00;
    if (m == fw_loader_pkg::MSG_SINGLE) begin
      r = c;
    end else if (i == 4'h0) begin
      r = `LDR_CH_CR;
    end else if (i == 4'h1) begin
      r = `LDR_CH_LF;
    end else if (m == fw_loader_pkg::MSG_PROMPT) begin
      case (i)
        4'h2: r = 8'h42;
        4'h3: r = 8'h4c;
        4'h4: r = 8'h20;
        default: r = 8'h3e;
      endcase
    end else if (i >= msg_len(m) - 4'h2) begin
      r = (i == msg_len(m) - 4'h2) ? `LDR_CH_CR : `LDR_CH_LF;
    end else if (m == fw_loader_pkg::MSG_COMPLETE) begin
      case (i)
        4'h2: r = 8'h63;
        4'h3: r = 8'h6f;
        4'h4: r = 8'h6d;
        4'h5: r = 8'h70;
        4'h6: r = 8'h6c;
        4'h7: r = 8'h65;
        4'h8: r = 8'h74;
        default: r = 8'h65;
      endcase
    end else begin
      case (i)
        4'h2: r = 8'h61;
        4'h3: r = 8'h62;
        4'h4: r = 8'h6f;
        4'h5: r = 8'h72;
        4'h6: r = 8'h74;
        4'h7: r = 8'h65;
        default: r = 8'h64;
      endcase
    end
    msg_char = r;
  endfunction

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cur <= fw_loader_pkg::MSG_PROMPT;
      single <= 8'h00;
      idx <= 4'h0;
      busy_o <= 1'b0;
      tx_valid_o <= 1'b0;
      tx_data_o <= 8'h00;
    end else if (!busy_o) begin
      if (start_i) begin
        cur <= sel_i;
        single <= ch_i;
        idx <= 4'h0;
        busy_o <= 1'b1;
      end
    end else if (tx_valid_o) begin
      if (tx_ready_i) begin
        tx_valid_o <= 1'b0;
      end
    end else if (idx == msg_len(cur)) begin
      busy_o <= 1'b0;
    end else begin
      tx_data_o <= msg_char(cur, idx, single);
      tx_valid_o <= 1'b1;
      idx <= idx + 4'h1;
    end
  end

endmodule
`default_nettype wire

// file: verif/fw_update_loader_checker.sv
// Port assertions for the firmware update loader
`timescale 1ns/1ps
`default_nettype none
module fw_update_loader_checker (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic flash_req_o,
  input wire logic [23:0] flash_addr_o,
  input wire logic flash_ack_i,
  input wire logic flash_err_i,
  input wire logic app_run_o,
  input wire logic loader_active_o,
  input wire logic load_busy_o,
  input wire logic launch_o
);
  default clocking dc @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // ****
  // Checks
  // ****
  chk_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("tx byte changed before acceptance");
  chk_tx_gap: assert property (tx_valid_o && tx_ready_i |=> !tx_valid_o)
    else $error("no idle cycle after accepted byte");
  chk_one_mode: assert property (!(app_run_o && loader_active_o))
    else $error("application and loader both active");
  chk_stay_loader: assert property ($fell(loader_active_o) |-> launch_o || $past(launch_o))
    else $error("loader left without launch");
  chk_launch_pulse: assert property (launch_o |=> !launch_o)
    else $error("launch longer than one cycle");
  chk_launch_run: assert property (launch_o |=> app_run_o)
    else $error("application not started after launch");
  chk_busy_in_ldr: assert property (load_busy_o |-> loader_active_o)
    else $error("upload busy outside loader");
  chk_flash_busy: assert property (flash_req_o |-> load_busy_o)
    else $error("flash write outside upload");
  chk_addr_step: assert property (flash_req_o && flash_ack_i && !flash_err_i |=>
    !flash_req_o || flash_addr_o == $past(flash_addr_o) + 24'h000001)
    else $error("flash address did not advance by one");
  chk_err_stop: assert property (flash_ack_i && flash_err_i |-> ##[1:4] !flash_req_o)
    else $error("flash writes continue after error");
  cover property (launch_o);
  cover property (flash_ack_i && flash_err_i);
  cover property ($fell(load_busy_o));
endmodule
`default_nettype wire

// file: verif/ldr_host_model.sv
// Host model on the loader byte stream
`timescale 1ns/1ps
`default_nettype none
module ldr_host_model (
  input wire logic clk_sys_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic tx_stb_i,
  output logic ready_o,
  output logic [7:0] rx_byte_o,
  output logic rx_stb_o
);
  logic [7:0] got[$];
  initial begin
    ready_o = 1'b0;
    rx_byte_o = 8'h00;
    rx_stb_o = 1'b0;
  end
  // ****
  // Receive side
  // ****
  // Random stalls only, no flow control lines
  always @(negedge clk_sys_i) ready_o <= ($urandom % 3) != 0;
  always @(posedge clk_sys_i) begin
    if (tx_stb_i && ready_o) begin
      got.push_back(tx_byte_i);
    end
  end
  // Whole bytes in order, idle data inverted
  task automatic send(input logic [7:0] b);
    @(negedge clk_sys_i);
    rx_byte_o = b;
    rx_stb_o = 1'b1;
    @(negedge clk_sys_i);
    rx_stb_o = 1'b0;
    rx_byte_o = ~b;
  endtask
endmodule
`default_nettype wire

// file: verif/serial_firmware_update_loader_bench.sv
// Self-checking bench for the firmware update loader
`timescale 1ns/1ps
`default_nettype none
module serial_firmware_update_loader_bench;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic din_i, sleep_request_line_i, rts_i, app_valid_i, app_jump_i;
  logic flash_ack_i = 1'b0;
  logic flash_err_i = 1'b0;
  logic [7:0] rx_data_i, tx_data_o, flash_wdata_o, fl_d;
  logic rx_valid_i, tx_ready_i, tx_valid_o, flash_req_o;
  logic app_run_o, loader_active_o, load_busy_o, launch_o;
  logic [23:0] flash_addr_o;
  logic [7:0] exp_fl[$];
  int error_cnt = 0;
  int samples_checked = 0;
  int fl_n = 0;
  bit fl_err = 1'b0;
  string prompt_s;
  always #2.5 clk_sys_i = ~clk_sys_i;
  fw_update_loader #(.FIRST_BLK_CYCLES(36'd2000), .POLL_CYCLES(36'd300)) dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .din_i(din_i),
    .sleep_request_line_i(sleep_request_line_i), .rts_i(rts_i),
    .app_valid_i(app_valid_i), .app_jump_i(app_jump_i), .rx_data_i(rx_data_i),
    .rx_valid_i(rx_valid_i), .tx_ready_i(tx_ready_i), .tx_data_o(tx_data_o),
    .tx_valid_o(tx_valid_o), .flash_req_o(flash_req_o), .flash_addr_o(flash_addr_o),
    .flash_wdata_o(flash_wdata_o), .flash_ack_i(flash_ack_i), .flash_err_i(flash_err_i),
    .app_run_o(app_run_o), .loader_active_o(loader_active_o),
    .load_busy_o(load_busy_o), .launch_o(launch_o));
  ldr_host_model host (.clk_sys_i(clk_sys_i), .tx_byte_i(tx_data_o), .tx_stb_i(tx_valid_o),
    .ready_o(tx_ready_i), .rx_byte_o(rx_data_i), .rx_stb_o(rx_valid_i));
  // ****
  // Helpers
  // ****
  task automatic final_report;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [23:0] a, input logic [23:0] e);
    samples_checked++;
    if (a !== e) begin
      $display("[ERR] %0t got %h exp %h", $time, a, e);
      error_cnt++;
    end
  endtask
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {b, 8'h00};
    for (int k = 0; k < 8; k++) c = c[15] ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
    return c;
  endfunction
  task automatic get_b(output logic [7:0] b);
    int w;
    w = 0;
    while (host.got.size() == 0) begin
      @(negedge clk_sys_i);
      w++;
      if (w > 5000) begin
        error_cnt++;
        final_report();
      end
    end
    b = host.got.pop_front();
    repeat (4) @(negedge clk_sys_i);
  endtask
  task automatic expect_str(input string s);
    logic [7:0] b;
    for (int i = 0; i < s.len(); i++) begin
      get_b(b);
      chk(b, s[i]);
    end
  endtask
  task automatic do_reset(input logic av, input logic sl, input logic rt, input logic dn);
    rst_i = 1'b1;
    app_valid_i = av;
    sleep_request_line_i = sl;
    rts_i = rt;
    din_i = dn;
    repeat (10) @(negedge clk_sys_i);
    host.got.delete();
    rst_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
  endtask
  task automatic quiet;
    logic seen;
    seen = 1'b0;
    repeat (40) begin
      @(negedge clk_sys_i);
      seen = seen | launch_o;
    end
    chk(seen, 1'b0);
    chk(24'(host.got.size()), 24'h0);
  endtask
  task automatic upload;
    logic [7:0] b;
    exp_fl.delete();
    fl_n = 0;
    host.send(8'h31);
    get_b(b);
    chk(b, 8'h43);
  endtask
  task automatic send_blk(input logic [7:0] n, input bit bad);
    logic [7:0] d;
    logic [15:0] c;
    c = 16'h0000;
    host.send(8'h01);
    host.send(n);
    host.send(~n);
    for (int i = 0; i < 128; i++) begin
      d = 8'($urandom);
      c = crc_step(c, d);
      host.send(d);
      if (!bad) exp_fl.push_back(d);
    end
    if (bad) c = ~c;
    host.send(c[15:8]);
    host.send(c[7:0]);
  endtask
  // Flash responder with random ack delay
  always @(negedge clk_sys_i) begin
    if (flash_ack_i) begin
      flash_ack_i <= 1'b0;
      flash_err_i <= 1'b0;
    end else if (flash_req_o && ($urandom % 2) == 1) begin
      fl_d = exp_fl.size() > 0 ? exp_fl.pop_front() : 8'h00;
      chk(flash_addr_o, 24'(fl_n));
      chk(flash_wdata_o, fl_d);
      flash_ack_i <= 1'b1;
      flash_err_i <= fl_err;
      fl_err = 1'b0;
      fl_n++;
    end
  end
  // ****
  // Scenarios
  // ****
  initial begin
    logic [7:0] b;
    logic [7:0] c;
    int t;
    void'($urandom(96));
    din_i = 1'b1;
    sleep_request_line_i = 1'b1;
    rts_i = 1'b0;
    app_valid_i = 1'b1;
    app_jump_i = 1'b0;
    prompt_s = "\r\nxx >";
    prompt_s.putc(2, 8'h42);
    prompt_s.putc(3, 8'h4c);
    do_reset(1'b1, 1'b1, 1'b0, 1'b1);
    chk(app_run_o, 1'b1);
    chk(loader_active_o, 1'b0);
    app_jump_i = 1'b1;
    @(negedge clk_sys_i);
    app_jump_i = 1'b0;
    expect_str(prompt_s);
    chk(loader_active_o, 1'b1);
    do_reset(1'b1, 1'b0, 1'b1, 1'b0);
    expect_str(prompt_s);
    host.send(8'h0d);
    expect_str(prompt_s);
    do c = 8'($urandom); while (c inside {8'h31, 8'h32, 8'h0d});
    host.send(c);
    quiet();
    host.send(8'h32);
    quiet();
    upload();
    send_blk(8'h01, 1'b0);
    get_b(b);
    chk(b, 8'h06);
    chk(24'(fl_n), 24'd128);
    send_blk(8'h02, 1'b1);
    get_b(b);
    chk(b, 8'h15);
    send_blk(8'h02, 1'b0);
    get_b(b);
    chk(b, 8'h06);
    chk(24'(fl_n), 24'd256);
    host.send(8'h04);
    get_b(b);
    chk(b, 8'h06);
    expect_str("\r\ncomplete\r\n");
    expect_str(prompt_s);
    host.send(8'h32);
    t = 0;
    while (!launch_o && t < 10) begin
      @(negedge clk_sys_i);
      t++;
    end
    chk(launch_o, 1'b1);
    @(negedge clk_sys_i);
    chk(app_run_o, 1'b1);
    do_reset(1'b0, 1'b1, 1'b0, 1'b1);
    expect_str(prompt_s);
    upload();
    t = 0;
    while (t < 3000) begin
      @(negedge clk_sys_i);
      t++;
      while (host.got.size() > 0 && host.got[0] === 8'h43) void'(host.got.pop_front());
      if (host.got.size() > 0) break;
    end
    chk(t >= 1900 && t <= 2700, 1'b1);
    expect_str("\r\naborted\r\n");
    expect_str(prompt_s);
    upload();
    host.send(8'h18);
    expect_str("\r\naborted\r\n");
    expect_str(prompt_s);
    chk(load_busy_o, 1'b0);
    upload();
    fl_err = 1'b1;
    send_blk(8'h01, 1'b0);
    expect_str("\r\naborted\r\n");
    expect_str(prompt_s);
    upload();
    send_blk(8'h01, 1'b0);
    chk(load_busy_o, 1'b1);
    do_reset(1'b0, 1'b1, 1'b0, 1'b1);
    expect_str(prompt_s);
    host.send(8'h32);
    quiet();
    final_report();
  end
endmodule
bind fw_update_loader fw_update_loader_checker chk_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
  .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
  .flash_req_o(flash_req_o), .flash_addr_o(flash_addr_o), .flash_ack_i(flash_ack_i),
  .flash_err_i(flash_err_i), .app_run_o(app_run_o), .loader_active_o(loader_active_o),
  .load_busy_o(load_busy_o), .launch_o(launch_o));
`default_nettype wire
